// ===== core/sfwr_device.sv
// Frequency word register bank with reference path and fast-lock sequencer
//
// Overview of operation
// - 24-bit words shift in MSB first
// - latch strobe rise copies word by address
// - frequency word uses address 000
// - frequency word top bit written zero
// - bits 22..15 integer part, 26..255
// - bits 14..3 numerator, below modulus
// - divider loads on next phase-detector cycle
// - fast lock: pump at maximum until timeout
// - switches close until own timeouts
// - modulus and phase words held in shadow
// - reference fields applied on frequency write
// - modulus/reference word uses address 001
// - scale bit raises pump current 25%
// - halving bit adds divide-by-two toggle
// - modulus word bit 21 written zero
// - doubler bit doubles reference edges
// - 4-bit reference counter, 1..15
// - 12-bit modulus, 13..4095
//
// The implementer's own choices: strobed register access and the address map.
`include "sfwr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sfwr_device (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	sfwr_if.dev              link,
	input  wire logic        reference_input_in,
	input  wire logic [8:0]  pump_current_timeout_in,
	input  wire logic [8:0]  loop_switch_a_timeout_in,
	input  wire logic [8:0]  loop_switch_b_timeout_in,
	input  wire logic [8:0]  loop_switch_c_timeout_in,
	output logic      [7:0]  int_value_out,
	output logic      [11:0] fraction_numerator_out,
	output logic      [11:0] fraction_modulus_out,
	output logic      [3:0]  ref_count_out,
	output logic             ref_half_out,
	output logic             doubler_out,
	output logic             prescaler_out,
	output logic             pump_current_scale_out,
	output logic      [11:0] phase_seed_out,
	output logic             pfd_tick_out,
	output logic             pump_max_out,
	output logic             loop_switch_a_out,
	output logic             loop_switch_b_out,
	output logic             loop_switch_c_out
);
	sfwr_pkg::sfwr_dev_state_t s;
	sfwr_pkg::sfwr_dev_state_t next_s;

	logic        sclk_rise;
	logic        strobe_rise;
	logic        ref_evt;
	logic        r_div;
	logic        tick;
	logic [10:0] pump_lim;
	logic [10:0] swa_lim;
	logic [10:0] swb_lim;
	logic [10:0] swc_lim;

	// Timers run at a quarter of the phase-detector rate
	assign pump_lim = {pump_current_timeout_in, 2'b00};
	assign swa_lim = {loop_switch_a_timeout_in, 2'b00};
	assign swb_lim = {loop_switch_b_timeout_in, 2'b00};
	assign swc_lim = {loop_switch_c_timeout_in, 2'b00};

	always_comb
	begin
		next_s = s;
		next_s.sclk_q = link.sclk;
		next_s.strobe_q = link.latch_strobe;
		next_s.ref_q = reference_input_in;
		sclk_rise = link.sclk & ~s.sclk_q;
		strobe_rise = link.latch_strobe & ~s.strobe_q;

		if (sclk_rise)
		begin
			next_s.shift = {s.shift[22:0], link.sdata};
		end

		ref_evt = (reference_input_in & ~s.ref_q)
			| (s.dbl & ~reference_input_in & s.ref_q);

		r_div = 1'b0;
		if (ref_evt)
		begin
			if (({1'b0, s.r_cnt} + 5'h01) >= {1'b0, s.r_val})
			begin
				next_s.r_cnt = 4'h0;
				r_div = 1'b1;
			end
			else
			begin
				next_s.r_cnt = s.r_cnt + 4'h1;
			end
		end

		if (r_div)
		begin
			next_s.half_tgl = ~s.half_tgl;
		end
		tick = s.half ? (r_div & s.half_tgl) : r_div;
		next_s.pfd_tick = tick;

		// Saturating so a long idle spell cannot wrap back into range
		if (tick && (s.tmo_cnt != `SFWR_TMO_MAX))
		begin
			next_s.tmo_cnt = s.tmo_cnt + 11'h001;
		end

		case (s.lock)
			sfwr_pkg::LK_PUMP:
			begin
				if (s.tmo_cnt >= pump_lim)
				begin
					next_s.lock = sfwr_pkg::LK_SWITCH;
				end
			end
			sfwr_pkg::LK_SWITCH:
			begin
				if ((s.tmo_cnt >= swa_lim) && (s.tmo_cnt >= swb_lim)
					&& (s.tmo_cnt >= swc_lim))
				begin
					next_s.lock = sfwr_pkg::LK_IDLE;
				end
			end
			sfwr_pkg::LK_IDLE:
			begin
				next_s.lock = sfwr_pkg::LK_IDLE;
			end
			default:
			begin
				next_s.lock = sfwr_pkg::LK_IDLE;
			end
		endcase

		if (tick && s.upd_pend)
		begin
			next_s.upd_pend = 1'b0;
			next_s.int_val = s.int_pend;
			next_s.numer_val = s.numer_pend;
			next_s.modulus_val = s.shadow_setup[`SFWR_M_MODULUS_HI:`SFWR_M_MODULUS_LO];
			next_s.r_val = s.shadow_setup[`SFWR_M_R_HI:`SFWR_M_R_LO];
			next_s.half = s.shadow_setup[`SFWR_M_HALF];
			next_s.scale = s.shadow_setup[`SFWR_M_SCALE];
			next_s.dbl = s.shadow_setup[`SFWR_M_DBL];
			next_s.pre = s.shadow_setup[`SFWR_M_PRE];
			next_s.phase_val = s.shadow_phase;
			next_s.lock = sfwr_pkg::LK_PUMP;
			next_s.tmo_cnt = 11'h000;
		end

		// Decoded after the update so a word latched on a tick stays pending
		// latch by address bits
		if (strobe_rise)
		begin
			case (s.shift[2:0])
				`SFWR_ADDR_FREQ:
				begin
					next_s.int_pend = s.shift[`SFWR_F_INT_HI:`SFWR_F_INT_LO];
					next_s.numer_pend = s.shift[`SFWR_F_NUMER_HI:`SFWR_F_NUMER_LO];
					next_s.upd_pend = 1'b1;
				end
				`SFWR_ADDR_MODREF:
				begin
					// whole word kept, split on apply
					next_s.shadow_setup = s.shift;
				end
				`SFWR_ADDR_PHASE:
				begin
					next_s.shadow_phase = s.shift[`SFWR_P_HI:`SFWR_P_LO];
				end
				default:
				begin
					next_s.shadow_phase = next_s.shadow_phase;
				end
			endcase
		end

		next_s.pump_max = (next_s.lock == sfwr_pkg::LK_PUMP);
		next_s.sw_a = (next_s.lock == sfwr_pkg::LK_SWITCH) && (next_s.tmo_cnt < swa_lim);
		next_s.sw_b = (next_s.lock == sfwr_pkg::LK_SWITCH) && (next_s.tmo_cnt < swb_lim);
		next_s.sw_c = (next_s.lock == sfwr_pkg::LK_SWITCH) && (next_s.tmo_cnt < swc_lim);
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.shadow_setup <= {5'h00, `SFWR_R_RST, `SFWR_MODULUS_RST, `SFWR_ADDR_MODREF};
			s.shadow_phase <= `SFWR_PHASE_RST;
			s.int_pend <= `SFWR_INT_RST;
			s.numer_pend <= `SFWR_NUMER_RST;
			s.int_val <= `SFWR_INT_RST;
			s.numer_val <= `SFWR_NUMER_RST;
			s.modulus_val <= `SFWR_MODULUS_RST;
			s.r_val <= `SFWR_R_RST;
			s.phase_val <= `SFWR_PHASE_RST;
			s.tmo_cnt <= `SFWR_TMO_MAX;
			s.lock <= sfwr_pkg::LK_IDLE;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign int_value_out = s.int_val;
	assign fraction_numerator_out = s.numer_val;
	assign fraction_modulus_out = s.modulus_val;
	assign ref_count_out = s.r_val;
	assign ref_half_out = s.half;
	assign doubler_out = s.dbl;
	assign prescaler_out = s.pre;
	assign pump_current_scale_out = s.scale;
	assign phase_seed_out = s.phase_val;
	assign pfd_tick_out = s.pfd_tick;
	assign pump_max_out = s.pump_max;
	assign loop_switch_a_out = s.sw_a;
	assign loop_switch_b_out = s.sw_b;
	assign loop_switch_c_out = s.sw_c;
endmodule : sfwr_device
`default_nettype wire

// ===== core/sfwr_host.sv
// Serial loader that sends software words to the register bank
`include "sfwr_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sfwr_host (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	sfwr_if.host             link,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out
);
	sfwr_pkg::sfwr_host_state_t s;
	sfwr_pkg::sfwr_host_state_t next_s;

	logic        busy;
	logic        div_done;
	logic        bad;
	logic [23:0] clean;
	logic [2:0]  waddr;

	assign busy = (s.state != sfwr_pkg::TX_IDLE);
	assign div_done = (s.div == (`SFWR_SCLK_HALF - 4'h1));
	assign waddr = wdata_in[2:0];

	always_comb
	begin
		next_s = s;
		next_s.rdata = 32'h0000_0000;
		clean = wdata_in[23:0];
		bad = 1'b0;
		if (waddr == `SFWR_ADDR_FREQ)
		begin
			clean[`SFWR_F_RSV] = 1'b0;
			bad = (wdata_in[`SFWR_F_INT_HI:`SFWR_F_INT_LO] < `SFWR_INT_MIN)
				|| (wdata_in[`SFWR_F_NUMER_HI:`SFWR_F_NUMER_LO] >= s.last_modulus);
		end
		else if (waddr == `SFWR_ADDR_MODREF)
		begin
			clean[`SFWR_M_RSV] = 1'b0;
			bad = (wdata_in[`SFWR_M_R_HI:`SFWR_M_R_LO] < `SFWR_R_MIN)
				|| (wdata_in[`SFWR_M_MODULUS_HI:`SFWR_M_MODULUS_LO] < `SFWR_MODULUS_MIN);
		end

		if (busy)
		begin
			next_s.div = div_done ? 4'h0 : (s.div + 4'h1);
		end

		case (s.state)
			sfwr_pkg::TX_LOW:
			begin
				if (div_done)
				begin
					next_s.state = sfwr_pkg::TX_HIGH;
					next_s.sclk = 1'b1;
				end
			end
			sfwr_pkg::TX_HIGH:
			begin
				if (div_done && (s.bit_cnt == 5'h00))
				begin
					next_s.state = sfwr_pkg::TX_LATCH;
					next_s.sclk = 1'b0;
					next_s.strobe = 1'b1;
				end
				else if (div_done)
				begin
					next_s.state = sfwr_pkg::TX_LOW;
					next_s.sclk = 1'b0;
					next_s.word = {s.word[22:0], 1'b0};
					next_s.sdata = s.word[22];
					next_s.bit_cnt = s.bit_cnt - 5'h01;
				end
			end
			sfwr_pkg::TX_LATCH:
			begin
				if (div_done)
				begin
					next_s.state = sfwr_pkg::TX_GAP;
					next_s.strobe = 1'b0;
				end
			end
			sfwr_pkg::TX_GAP:
			begin
				if (div_done)
				begin
					next_s.state = sfwr_pkg::TX_IDLE;
				end
			end
			sfwr_pkg::TX_IDLE:
			begin
				next_s.div = 4'h0;
			end
			default:
			begin
				next_s.state = sfwr_pkg::TX_IDLE;
			end
		endcase

		// Clears first so a coinciding set still wins
		if (wr_in && (addr_in == `SFWR_HOST_STAT))
		begin
			next_s.drop = s.drop & ~wdata_in[`SFWR_ST_DROP];
			next_s.range_err = s.range_err & ~wdata_in[`SFWR_ST_RANGE];
		end
		if (wr_in && (addr_in == `SFWR_HOST_TX))
		begin
			if (busy)
			begin
				next_s.drop = 1'b1;
			end
			else if (bad)
			begin
				next_s.range_err = 1'b1;
			end
			else
			begin
				next_s.state = sfwr_pkg::TX_LOW;
				next_s.word = clean;
				next_s.sdata = clean[23];
				next_s.sclk = 1'b0;
				next_s.bit_cnt = `SFWR_BIT_LAST;
				next_s.div = 4'h0;
				if (waddr == `SFWR_ADDR_MODREF)
				begin
					next_s.last_modulus = clean[`SFWR_M_MODULUS_HI:`SFWR_M_MODULUS_LO];
				end
			end
		end

		if (rd_in && (addr_in == `SFWR_HOST_STAT))
		begin
			next_s.rdata = {29'h000_0000, s.range_err, s.drop, busy};
		end
		else if (rd_in && (addr_in == `SFWR_HOST_MODULUS))
		begin
			next_s.rdata = {20'h0_0000, s.last_modulus};
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.state <= sfwr_pkg::TX_IDLE;
			s.last_modulus <= `SFWR_MODULUS_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign link.sclk = s.sclk;
	assign link.sdata = s.sdata;
	assign link.latch_strobe = s.strobe;
	assign rdata_out = s.rdata;
endmodule : sfwr_host
`default_nettype wire

// ===== shared/sfwr_defs.svh
// Constants for the frequency word register bank and its serial loader
`ifndef SFWR_DEFS_SVH
`define SFWR_DEFS_SVH
// Address field of the serial word
`define SFWR_ADDR_FREQ 3'h0
`define SFWR_ADDR_MODREF 3'h1
`define SFWR_ADDR_PHASE 3'h2
// Frequency word fields
`define SFWR_F_RSV 23
`define SFWR_F_INT_HI 22
`define SFWR_F_INT_LO 15
`define SFWR_F_NUMER_HI 14
`define SFWR_F_NUMER_LO 3
// Modulus and reference word fields
`define SFWR_M_SCALE 23
`define SFWR_M_HALF 22
`define SFWR_M_RSV 21
`define SFWR_M_PRE 20
`define SFWR_M_DBL 19
`define SFWR_M_R_HI 18
`define SFWR_M_R_LO 15
`define SFWR_M_MODULUS_HI 14
`define SFWR_M_MODULUS_LO 3
// Phase word field
`define SFWR_P_HI 14
`define SFWR_P_LO 3
// Reset values
`define SFWR_INT_RST 8'h1A
`define SFWR_NUMER_RST 12'h000
`define SFWR_MODULUS_RST 12'hFFF
`define SFWR_R_RST 4'h1
`define SFWR_PHASE_RST 12'h000
// Legal minimums
`define SFWR_INT_MIN 8'h1A
`define SFWR_MODULUS_MIN 12'h00D
`define SFWR_R_MIN 4'h1
// Timing: serial half period in clock cycles
`define SFWR_SCLK_HALF 4'h2
`define SFWR_BIT_LAST 5'h17
`define SFWR_TMO_MAX 11'h7FF
// Host register offsets and status bits
`define SFWR_HOST_TX 8'h00
`define SFWR_HOST_STAT 8'h04
`define SFWR_HOST_MODULUS 8'h08
`define SFWR_ST_BUSY 0
`define SFWR_ST_DROP 1
`define SFWR_ST_RANGE 2
`endif

// ===== shared/sfwr_if.sv
// Three-wire serial programming link between loader and register bank
`timescale 1ns/100ps
`default_nettype none
interface sfwr_if;
	logic sclk;
	logic sdata;
	logic latch_strobe;
	modport dev (input sclk, input sdata, input latch_strobe);
	modport host (output sclk, output sdata, output latch_strobe);
endinterface : sfwr_if
`default_nettype wire

// ===== shared/sfwr_pkg.sv
// Types for the frequency word register bank and its serial loader
`default_nettype none
package sfwr_pkg;
	typedef enum logic [1:0] {
		LK_IDLE   = 2'b00,
		LK_PUMP   = 2'b01,
		LK_SWITCH = 2'b10
	} sfwr_lock_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_LOW   = 3'b001,
		TX_HIGH  = 3'b010,
		TX_LATCH = 3'b011,
		TX_GAP   = 3'b100
	} sfwr_tx_t;

	typedef struct packed {
		logic        sclk_q;
		logic        strobe_q;
		logic        ref_q;
		logic [23:0] shift;
		logic [23:0] shadow_setup;
		logic [11:0] shadow_phase;
		logic [7:0]  int_pend;
		logic [11:0] numer_pend;
		logic        upd_pend;
		logic [7:0]  int_val;
		logic [11:0] numer_val;
		logic [11:0] modulus_val;
		logic [3:0]  r_val;
		logic        half;
		logic        scale;
		logic        dbl;
		logic        pre;
		logic [11:0] phase_val;
		logic [3:0]  r_cnt;
		logic        half_tgl;
		logic        pfd_tick;
		logic [10:0] tmo_cnt;
		sfwr_lock_t  lock;
		logic        pump_max;
		logic        sw_a;
		logic        sw_b;
		logic        sw_c;
	} sfwr_dev_state_t;

	typedef struct packed {
		sfwr_tx_t    state;
		logic [23:0] word;
		logic [4:0]  bit_cnt;
		logic [3:0]  div;
		logic        sclk;
		logic        sdata;
		logic        strobe;
		logic [11:0] last_modulus;
		logic        drop;
		logic        range_err;
		logic [31:0] rdata;
	} sfwr_host_state_t;
endpackage : sfwr_pkg
`default_nettype wire

// ===== test/sfwr_link_monitor.sv
// Protocol checker for the three-wire programming link
`timescale 1ns/100ps
`default_nettype none
module sfwr_link_monitor (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic latch_strobe_in
);
	logic       sclk_q;
	logic [4:0] rise_cnt;

	// Bits shifted since the last latch; a dropped word never reaches the wire
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sclk_q   <= 1'b0;
			rise_cnt <= 5'h00;
		end
		else
		begin
			sclk_q   <= sclk_in;
			rise_cnt <= latch_strobe_in ? 5'h00 : rise_cnt + {4'h0, sclk_in & ~sclk_q};
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	property p_sclk_hi; $rose(sclk_in) |=> sclk_in ##1 !sclk_in; endproperty
	a_sclk_hi: assert property (p_sclk_hi) else $error("serial clock high phase wrong");
	property p_sclk_lo; $fell(sclk_in) |=> !sclk_in; endproperty
	a_sclk_lo: assert property (p_sclk_lo) else $error("serial clock low phase short");
	property p_data; sclk_in |-> $stable(sdata_in); endproperty
	a_data: assert property (p_data) else $error("data moved while clock high");
	property p_strobe_len; $rose(latch_strobe_in) |=> latch_strobe_in ##1 !latch_strobe_in; endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("latch pulse not two cycles");
	property p_strobe_low; latch_strobe_in |-> !sclk_in; endproperty
	a_strobe_low: assert property (p_strobe_low) else $error("clock high during latch");
	property p_bits; $rose(latch_strobe_in) |-> rise_cnt == 5'h18; endproperty
	a_bits: assert property (p_bits) else $error("latched word not 24 bits");
	property p_last; (rise_cnt == 5'h17 && sclk_in && !sclk_q) |-> ##[1:3] $rose(latch_strobe_in); endproperty
	a_last: assert property (p_last) else $error("no latch after last bit");
	property p_gap; $fell(latch_strobe_in) |-> !sclk_in ##1 !sclk_in; endproperty
	a_gap: assert property (p_gap) else $error("clock restarted in latch gap");

	c_latch: cover property ($rose(latch_strobe_in));
	c_word: cover property (rise_cnt == 5'h17 && sclk_in && !sclk_q);
	c_gap: cover property ($fell(latch_strobe_in));
endmodule : sfwr_link_monitor
`default_nettype wire

// ===== test/sfwr_testbench.sv
// Bench joining the serial loader to the register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        mclk_in;
	logic        rst_in;
	logic        ref_in = 1'b0;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [7:0]  int_v;
	logic [11:0] numer;
	logic [11:0] modv;
	logic [11:0] phase;
	logic [3:0]  rcnt;
	logic        half, dbl, pre, scale, tick, pmax, sw_a, sw_b, sw_c;
	logic        sq = 1'b0;
	logic [23:0] sniff;
	logic [31:0] rv;
	int          err_count = 0;
	int          num_checks = 0;
	int          cyc = 0;

	sfwr_if link ();
	sfwr_host sfwr_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .link(link), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
	// Timeouts in units of four ticks; staggered so the switches open in the order a, b, c
	sfwr_device sfwr_device_inst (.mclk_in(mclk_in), .rst_in(rst_in), .link(link), .reference_input_in(ref_in),
		.pump_current_timeout_in(9'h002), .loop_switch_a_timeout_in(9'h003), .loop_switch_b_timeout_in(9'h004),
		.loop_switch_c_timeout_in(9'h005), .int_value_out(int_v), .fraction_numerator_out(numer),
		.fraction_modulus_out(modv), .ref_count_out(rcnt), .ref_half_out(half), .doubler_out(dbl),
		.prescaler_out(pre), .pump_current_scale_out(scale), .phase_seed_out(phase), .pfd_tick_out(tick),
		.pump_max_out(pmax), .loop_switch_a_out(sw_a), .loop_switch_b_out(sw_b), .loop_switch_c_out(sw_c));
	sfwr_link_monitor sfwr_link_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(link.sclk),
		.sdata_in(link.sdata), .latch_strobe_in(link.latch_strobe));

	initial
	begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	// Reference at a quarter of the clock; sniffer rebuilds each word off the wire
	always @(posedge mclk_in)
	begin
		cyc    <= cyc + 1;
		ref_in <= cyc[1];
		sq     <= link.sclk;
		if (link.sclk && !sq)
			sniff <= {sniff[22:0], link.sdata};
		if (cyc == 20000)
		begin
			err_count++;
			summarize();
		end
	end

	task summarize;
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a);
		@(posedge mclk_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask : rd_reg

	task wait_idle;
		int i;
		rd_reg(8'h04);
		for (i = 0; i < 200 && rv[0] !== 1'b0; i++)
			rd_reg(8'h04);
		chk(rv[0], 1'b0);
	endtask : wait_idle

	task send(input logic [23:0] w);
		wr_reg(8'h00, {8'h00, w});
		wait_idle();
		chk(sniff, w);
	endtask : send

	function automatic logic sig(input int s);
		case (s)
			0: return pmax;
			1: return sw_a;
			2: return sw_b;
			4: return sw_c;
			default: return tick;
		endcase
	endfunction : sig

	task wait_sig(input int s, input logic v);
		int i;
		for (i = 0; i < 400 && sig(s) !== v; i++)
			@(posedge mclk_in) #1;
		chk(sig(s), v);
	endtask : wait_sig

	// Cycles between two ticks show the whole reference path at once
	task tick_gap(input int exp);
		int n;
		wait_sig(3, 1'b0);
		wait_sig(3, 1'b1);
		n = 0;
		do
		begin
			@(posedge mclk_in) #1;
			n++;
		end
		while (tick !== 1'b1 && n < 100);
		chk(n, exp);
	endtask : tick_gap

	task t_freq;
		chk(int_v, 8'h1A);
		chk(modv, 12'hFFF);
		chk(pmax, 1'b0);
		send({1'b0, 8'h40, 12'h123, 3'b000});
		wait_sig(3, 1'b1);
		chk(int_v, 8'h40);
		chk(numer, 12'h123);
		chk(pmax, 1'b1);
		wait_sig(0, 1'b0);
		@(posedge mclk_in) #1;
		chk({sw_a, sw_b, sw_c}, 3'b111);
		wait_sig(1, 1'b0);
		chk(sw_b, 1'b1);
		wait_sig(2, 1'b0);
		chk(sw_c, 1'b1);
		wait_sig(4, 1'b0);
		tick_gap(4);
	endtask : t_freq

	task t_shadow;
		send({1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h3, 12'h064, 3'b001});
		send({9'h000, 12'h0AB, 3'b010});
		chk({modv, rcnt, half, dbl, pre, scale}, {12'hFFF, 4'h1, 4'h0});
		chk(phase, 12'h000);
		send({1'b0, 8'hFF, 12'h032, 3'b000});
		wait_sig(3, 1'b1);
		chk(modv, 12'h064);
		chk(rcnt, 4'h3);
		chk({scale, half, pre, dbl}, 4'hF);
		chk(phase, 12'h0AB);
		chk({int_v, numer}, {8'hFF, 12'h032});
		tick_gap(12);
		rd_reg(8'h08);
		chk(rv, 32'h0000_0064);
	endtask : t_shadow

	task t_refuse;
		wr_reg(8'h00, {8'h00, 1'b0, 8'h10, 12'h000, 3'b000});
		wait_idle();
		chk(rv, 32'h0000_0004);
		wr_reg(8'h04, 32'h0000_0004);
		rd_reg(8'h04);
		chk(rv, 32'h0000_0000);
		wr_reg(8'h00, {8'h00, 1'b1, 8'h30, 12'h000, 3'b000});
		wr_reg(8'h00, {8'h00, 1'b0, 8'h31, 12'h000, 3'b000});
		wait_idle();
		chk(rv, 32'h0000_0002);
		chk(sniff, {1'b0, 8'h30, 12'h000, 3'b000});
		wait_sig(3, 1'b0);
		wait_sig(3, 1'b1);
		chk(int_v, 8'h30);
		rd_reg(8'h0C);
		chk(rv, 32'h0000_0000);
	endtask : t_refuse

	initial
	begin
		rst_in = 1'b1;
		addr   = 8'h00;
		wdata  = 32'h0000_0000;
		wr     = 1'b0;
		rd     = 1'b0;
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_freq();
		t_shadow();
		t_refuse();
		summarize();
	end
endmodule : testbench
`default_nettype wire
